// File: rtl/lioc_pkg.sv
// Package: register map, field layout, reset values and timing constants
`default_nettype none
package lioc_pkg;
  // Clock
  localparam int unsigned CLK_HZ  = 125_000_000;
  localparam int unsigned CLK_MHZ = 125;
  // Register indices and byte addresses (byte address is four times index)
  localparam logic [7:0]  IDX_I2C_TIMING  = 8'h13;
  localparam logic [7:0]  IDX_SWING_WAKE  = 8'h14;
  localparam logic [11:0] ADDR_I2C_TIMING = {2'b00, IDX_I2C_TIMING, 2'b00};
  localparam logic [11:0] ADDR_SWING_WAKE = {2'b00, IDX_SWING_WAKE, 2'b00};
  // Field positions
  localparam int unsigned LOCACK_BIT = 7;
  localparam int unsigned SH_LSB     = 5;
  localparam int unsigned RATE_LSB   = 2;
  localparam int unsigned TO_LSB     = 0;
  localparam int unsigned LVL_LSB    = 4;
  localparam int unsigned WAKE_BIT   = 0;
  // Reset values
  localparam logic       RST_LOCACK = 1'b1;
  localparam logic [1:0] RST_SH     = 2'h1;
  localparam logic [2:0] RST_RATE   = 3'h5;
  localparam logic [1:0] RST_TO     = 2'h2;
  localparam logic [3:0] RST_LVL    = 4'ha;
  localparam logic       RST_WAKE   = 1'b0;
  // Timing figures in their own units
  localparam int unsigned SH_SETUP_NS [4] = '{352, 469, 938, 1046};
  localparam int unsigned SH_HOLD_NS  [4] = '{117, 234, 352, 469};
  localparam int unsigned MST_BPS [8] =
    '{8470, 28300, 84700, 105000, 173000, 339000, 533000, 837000};
  localparam int unsigned TO_US [3] = '{64, 256, 1024};
  localparam logic       TO_OFF_CODE  = 1'b1;
  localparam logic [1:0] TO_NONE      = 2'h3;
  // Output swing
  localparam logic [3:0] LVL_MIN_CODE = 4'h1;
  localparam logic [3:0] LVL_MAX_CODE = 4'ha;
  localparam logic [5:0] LVL_STEP_MV  = 6'h32;

  // Least time in ns to whole clock cycles, rounded up
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  // Bit period in clock cycles for a given rate, rounded down
  function automatic int unsigned bps_to_cyc(input int unsigned bps);
    return CLK_HZ / bps;
  endfunction
endpackage
`default_nettype wire

// File: rtl/lioc_cfg_if.sv
// Interface: configuration fields passed from register bank to decoder
`default_nettype none
interface lioc_cfg_if;
  logic       local_ack_enable;
  logic [1:0] slave_setup_hold_sel;
  logic [2:0] master_bit_rate_sel;
  logic [1:0] slave_remote_timeout_sel;
  logic [3:0] coax_output_level;
  logic       remote_wake_disable;
  modport src (output local_ack_enable, slave_setup_hold_sel,
               master_bit_rate_sel, slave_remote_timeout_sel,
               coax_output_level, remote_wake_disable);
  modport dst (input local_ack_enable, slave_setup_hold_sel,
               master_bit_rate_sel, slave_remote_timeout_sel,
               coax_output_level, remote_wake_disable);
endinterface
`default_nettype wire

// File: rtl/lioc_decode.sv
// Decoder: turns register codes into cycle counts and control levels
`default_nettype none
module lioc_decode
  import lioc_pkg::*;
#(
  parameter int unsigned P_MST_DIV0 = bps_to_cyc(MST_BPS[0]),
  parameter int unsigned P_MST_DIV1 = bps_to_cyc(MST_BPS[1]),
  parameter int unsigned P_TO_CYC0  = TO_US[0] * CLK_MHZ,
  parameter int unsigned P_TO_CYC1  = TO_US[1] * CLK_MHZ,
  parameter int unsigned P_TO_CYC2  = TO_US[2] * CLK_MHZ
) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst_n,
  lioc_cfg_if.dst    cfg,
  output logic [7:0]  o_setup_cyc,
  output logic [7:0]  o_hold_cyc,
  output logic [15:0] o_bit_div,
  output logic [17:0] o_timeout_cyc,
  output logic        o_timeout_en,
  output logic [9:0]  o_swing_mv,
  output logic        o_swing_legal,
  output logic        o_wake_rx_en
);
  logic [7:0]  setup_d, setup_q, hold_d, hold_q;
  logic [15:0] div_d, div_q;
  logic [17:0] to_d, to_q;
  logic        to_en_d, to_en_q, legal_d, legal_q, wake_d, wake_q;
  logic [9:0]  mv_d, mv_q;

  // Next values from the configuration codes
  always_comb begin
    setup_d = 8'(ns_to_cyc(SH_SETUP_NS[cfg.slave_setup_hold_sel]));
    hold_d  = 8'(ns_to_cyc(SH_HOLD_NS[cfg.slave_setup_hold_sel]));
    case (cfg.master_bit_rate_sel)
      3'h0:    div_d = 16'(P_MST_DIV0);
      3'h1:    div_d = 16'(P_MST_DIV1);
      default: div_d = 16'(bps_to_cyc(MST_BPS[cfg.master_bit_rate_sel]));
    endcase
    to_en_d = 1'b1;
    case (cfg.slave_remote_timeout_sel)
      2'h0:    to_d = 18'(P_TO_CYC0);
      2'h1:    to_d = 18'(P_TO_CYC1);
      2'h2:    to_d = 18'(P_TO_CYC2);
      default: begin
        to_d    = 18'h0_0000;
        to_en_d = 1'b0;
      end
    endcase
    legal_d = (cfg.coax_output_level >= LVL_MIN_CODE) &&
              (cfg.coax_output_level <= LVL_MAX_CODE);
    mv_d    = legal_d ? 10'(cfg.coax_output_level * LVL_STEP_MV)
                      : 10'h000;
    wake_d  = !cfg.remote_wake_disable;
  end

  // Output registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      setup_q <= 8'h00;
      hold_q  <= 8'h00;
      div_q   <= 16'h0000;
      to_q    <= 18'h0_0000;
      to_en_q <= 1'b0;
      legal_q <= 1'b0;
      mv_q    <= 10'h000;
      wake_q  <= 1'b0;
    end else begin
      setup_q <= setup_d;
      hold_q  <= hold_d;
      div_q   <= div_d;
      to_q    <= to_d;
      to_en_q <= to_en_d;
      legal_q <= legal_d;
      mv_q    <= mv_d;
      wake_q  <= wake_d;
    end
  end

  assign o_setup_cyc   = setup_q;
  assign o_hold_cyc    = hold_q;
  assign o_bit_div     = div_q;
  assign o_timeout_cyc = to_q;
  assign o_timeout_en  = to_en_q;
  assign o_swing_mv    = mv_q;
  assign o_swing_legal = legal_q;
  assign o_wake_rx_en  = wake_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_SH_SETUP: assert property (
    (cfg.slave_setup_hold_sel == 2'h3) |=> (o_setup_cyc == 8'h83))
    else $error("setup count wrong for code 3");
  AST_TO_OFF: assert property (
    (cfg.slave_remote_timeout_sel == TO_NONE) |=> !o_timeout_en)
    else $error("timeout not disabled by code 3");
  AST_WAKE_RX: assert property (
    $changed(cfg.remote_wake_disable) |=> (o_wake_rx_en != $past(o_wake_rx_en)))
    else $error("wake receiver did not follow its control bit");
endmodule // lioc_decode
`default_nettype wire

// File: rtl/lioc_regs.sv
// Register bank: APB slave for bridge timing and output swing/wake config
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module lioc_regs
  import lioc_pkg::*;
#(
  parameter int unsigned P_MST_DIV0 = bps_to_cyc(MST_BPS[0]),
  parameter int unsigned P_MST_DIV1 = bps_to_cyc(MST_BPS[1]),
  parameter int unsigned P_TO_CYC0  = TO_US[0] * CLK_MHZ,
  parameter int unsigned P_TO_CYC1  = TO_US[1] * CLK_MHZ,
  parameter int unsigned P_TO_CYC2  = TO_US[2] * CLK_MHZ
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_local_ack_enable,
  output logic [7:0]       o_setup_cyc,
  output logic [7:0]       o_hold_cyc,
  output logic [15:0]      o_bit_div,
  output logic [17:0]      o_timeout_cyc,
  output logic             o_timeout_en,
  output logic [9:0]       o_swing_mv,
  output logic             o_swing_legal,
  output logic             o_wake_rx_en
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic       locack_d, locack_q;
  logic [1:0] sh_d, sh_q;
  logic [2:0] rate_d, rate_q;
  logic [1:0] to_d, to_q;
  logic [3:0] lvl_d, lvl_q;
  logic       wake_d, wake_q;
  logic [31:0] rdata_d, rdata_q;
  logic       hit_timing, hit_swing, wr_en, rd_setup;

  // Address decode
  always_comb begin
    hit_timing = 1'b0;
    hit_swing  = 1'b0;
    if (i_paddr == ADDR_I2C_TIMING) begin
      hit_timing = 1'b1;
    end else if (i_paddr == ADDR_SWING_WAKE) begin
      hit_swing = 1'b1;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !(hit_timing || hit_swing);
  assign wr_en     = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign rd_setup  = i_psel && !i_penable && !i_pwrite;

  // Field images of the two registers
  function automatic logic [31:0] img(input logic sel_swing,
                                      input logic a, input logic [1:0] b,
                                      input logic [2:0] c,
                                      input logic [1:0] d,
                                      input logic [3:0] e, input logic f);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (sel_swing) begin
      r[LVL_LSB +: 4] = e;
      r[WAKE_BIT]     = f; // Bits 3:1 stay zero
    end else begin
      r[LOCACK_BIT]    = a;
      r[SH_LSB +: 2]   = b;
      r[RATE_LSB +: 3] = c;
      r[TO_LSB +: 2]   = d;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next values: writes land at the access edge
  always_comb begin
    locack_d = locack_q;
    sh_d     = sh_q;
    rate_d   = rate_q;
    to_d     = to_q;
    lvl_d    = lvl_q;
    wake_d   = wake_q;
    if (wr_en && hit_timing) begin
      locack_d = i_pwdata[LOCACK_BIT];
      sh_d     = i_pwdata[SH_LSB +: 2];
      rate_d   = i_pwdata[RATE_LSB +: 3];
      to_d     = i_pwdata[TO_LSB +: 2];
    end else if (wr_en && hit_swing) begin
      lvl_d    = i_pwdata[LVL_LSB +: 4];   // Stored as written
      wake_d   = i_pwdata[WAKE_BIT];
    end
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = (hit_timing || hit_swing)
              ? img(hit_swing, locack_q, sh_q, rate_q, to_q, lvl_q, wake_q)
              : 32'h0000_0000;
    end
  end

  // Register update and reset values
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      locack_q <= RST_LOCACK;
      sh_q     <= RST_SH;
      rate_q   <= RST_RATE;
      to_q     <= RST_TO;
      lvl_q    <= RST_LVL;
      wake_q   <= RST_WAKE;
      rdata_q  <= 32'h0000_0000;
    end else begin
      locack_q <= locack_d;
      sh_q     <= sh_d;
      rate_q   <= rate_d;
      to_q     <= to_d;
      lvl_q    <= lvl_d;
      wake_q   <= wake_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_prdata           = rdata_q;
  assign o_local_ack_enable = locack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decoder behind the configuration interface
  lioc_cfg_if cfg ();
  assign cfg.local_ack_enable         = locack_q;
  assign cfg.slave_setup_hold_sel     = sh_q;
  assign cfg.master_bit_rate_sel      = rate_q;
  assign cfg.slave_remote_timeout_sel = to_q;
  assign cfg.coax_output_level        = lvl_q;
  assign cfg.remote_wake_disable      = wake_q;

  lioc_decode #(
    .P_MST_DIV0 (P_MST_DIV0),
    .P_MST_DIV1 (P_MST_DIV1),
    .P_TO_CYC0  (P_TO_CYC0),
    .P_TO_CYC1  (P_TO_CYC1),
    .P_TO_CYC2  (P_TO_CYC2)
  ) u_decode (
    .i_clk_sys     (i_clk_sys),
    .i_rst_n       (i_rst_n),
    .cfg           (cfg),
    .o_setup_cyc   (o_setup_cyc),
    .o_hold_cyc    (o_hold_cyc),
    .o_bit_div     (o_bit_div),
    .o_timeout_cyc (o_timeout_cyc),
    .o_timeout_en  (o_timeout_en),
    .o_swing_mv    (o_swing_mv),
    .o_swing_legal (o_swing_legal),
    .o_wake_rx_en  (o_wake_rx_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RESET_VALUES: assert property (@(posedge i_clk_sys)
    !i_rst_n |=> (o_local_ack_enable && sh_q == 2'h1 && rate_q == 3'h5 &&
                  to_q == 2'h2 && lvl_q == 4'ha && !wake_q))
    else $error("register reset values wrong");
  AST_LOCACK_WRITE: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_timing) |=> (o_local_ack_enable == $past(i_pwdata[7])))
    else $error("local ack bit did not take write");
  AST_SH_WRITE: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_timing && i_pwdata[6:5] == 2'h0) |=> ##1
      (o_setup_cyc == 8'h2c && o_hold_cyc == 8'h0f))
    else $error("setup/hold code 00 gave wrong counts");
  AST_RATE_WRITE: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_timing && i_pwdata[4:2] == 3'h7) |=> ##1
      (o_bit_div == 16'h0095))
    else $error("bit rate code 111 gave wrong divider");
  AST_TO_WRITE: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_timing && i_pwdata[1:0] == 2'h0) |=> ##1
      (o_timeout_en && o_timeout_cyc == 18'(P_TO_CYC0)))
    else $error("timeout code 00 gave wrong count");
  AST_SWING_LEGAL: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_swing) |=> ##1
      (o_swing_legal == ($past(i_pwdata[7:4], 2) inside {[4'h1:4'ha]})))
    else $error("swing legality flag wrong");
  AST_WAKE_WRITE: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (wr_en && hit_swing) |=> ##1 (o_wake_rx_en == !$past(i_pwdata[0], 2)))
    else $error("wake receiver enable wrong after write");
  AST_RSVD_ZERO: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    (rd_setup && hit_swing) |=> (o_prdata[31:8] == 24'h00_0000 &&
      o_prdata[3:1] == 3'h0))
    else $error("reserved bits read nonzero");
endmodule // lioc_regs
`default_nettype wire

// File: tb/lioc_apb_host.sv
// APB host model that programs the register bank one transfer at a time
`default_nettype none
module lioc_apb_host (
  input  wire logic        i_clk_sys,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
    o_pstrb   = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup, then access held until pready; released address and data lines are inverted
  // so a slave cannot lean on stale address or data
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er,
                      output logic to);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    o_psel   <= 1'b1;
    o_pwrite <= wr;
    o_paddr  <= a;
    o_pwdata <= d;
    o_pstrb  <= s;
    @(posedge i_clk_sys);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_pready !== 1'b1 && n < 50);
    to = (n >= 50);
    rd = i_prdata;
    er = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask
endmodule // lioc_apb_host
`default_nettype wire

// File: tb/test_link_i2c_and_output_config_regs.sv
// Bench: APB scenarios for the bridge timing and swing/wake registers
`default_nettype none
module test_link_i2c_and_output_config_regs;
  import lioc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Shortened long counts for the two slowest rates and the timeouts
  localparam int unsigned P_D0 = 20;
  localparam int unsigned P_D1 = 40;
  localparam int unsigned P_T0 = 10;
  localparam int unsigned P_T1 = 20;
  localparam int unsigned P_T2 = 40;

  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

  logic        clk_sys;
  logic        rst_n;
  logic        psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic        pready, pslverr, local_ack, to_en, swing_ok, wake_en;
  logic [7:0]  setup_cyc, hold_cyc, sh1, sh2;
  logic [15:0] bit_div;
  logic [17:0] to_cyc;
  logic [9:0]  swing_mv;
  int          err_total, n_tests;

  lioc_regs #(.P_MST_DIV0(P_D0), .P_MST_DIV1(P_D1), .P_TO_CYC0(P_T0),
              .P_TO_CYC1(P_T1), .P_TO_CYC2(P_T2)) i_dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .o_local_ack_enable(local_ack), .o_setup_cyc(setup_cyc),
    .o_hold_cyc(hold_cyc), .o_bit_div(bit_div), .o_timeout_cyc(to_cyc),
    .o_timeout_en(to_en), .o_swing_mv(swing_mv),
    .o_swing_legal(swing_ok), .o_wake_rx_en(wake_en));

  lioc_apb_host i_host (
    .i_clk_sys(clk_sys), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_pstrb(pstrb));

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected bit period and timeout for a code
  function automatic int unsigned exp_div(input logic [2:0] c);
    return (c == 3'h0) ? P_D0 : (c == 3'h1) ? P_D1 : CLK_HZ / MST_BPS[c];
  endfunction

  function automatic int unsigned exp_to(input logic [1:0] c);
    return (c == 2'h3) ? 0 : (c == 2'h2) ? P_T2 : (c == 2'h1) ? P_T1 : P_T0;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One transfer; a missing pready ends the run
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic e_err);
    logic er;
    logic to;
    i_host.xfer(wr, a, d, s, rdat, er, to);
    if (to) begin
      err_total++;
      $display("[FAIL] %0t no pready", $time);
      final_report();
    end
    `CHK(er, e_err)
  endtask

  // Decoded outputs two edges after a change, against both register bytes
  task automatic chk_out(input logic [7:0] r1, input logic [7:0] r2);
    logic [3:0] lv;
    logic       ok;
    lv = r2[7:4];
    ok = (lv >= 4'h1) && (lv <= 4'ha);
    @(negedge clk_sys);
    @(negedge clk_sys);
    `CHK(local_ack, r1[7])
    `CHK(setup_cyc, 8'((SH_SETUP_NS[r1[6:5]] * CLK_MHZ + 999) / 1000))
    `CHK(hold_cyc, 8'((SH_HOLD_NS[r1[6:5]] * CLK_MHZ + 999) / 1000))
    `CHK(bit_div, 16'(exp_div(r1[4:2])))
    `CHK(to_en, (r1[1:0] != 2'h3))
    `CHK(to_cyc, 18'(exp_to(r1[1:0])))
    `CHK(swing_ok, ok)
    `CHK(swing_mv, ok ? 10'(lv) * 10'h032 : 10'h000)
    `CHK(wake_en, ~r2[0])
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values at the outputs and on read-back
  task automatic t_reset();
    chk_out(8'hb6, 8'ha0);
    bus(1'b0, ADDR_I2C_TIMING, 32'h0000_0000, 4'hf, 1'b0);
    `CHK(rdat, 32'h0000_00b6)
    bus(1'b0, ADDR_SWING_WAKE, 32'h0000_0000, 4'hf, 1'b0);
    `CHK(rdat, 32'h0000_00a0)
    $display("test reset done");
  endtask

  // Every timing code, upper data bits set to prove they are dropped
  task automatic t_timing();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      sh1 = {c[0], c[1:0], c, ~c[1:0]};
      bus(1'b1, ADDR_I2C_TIMING, {24'hff_ffff, sh1}, 4'hf, 1'b0);
      chk_out(sh1, sh2);
      bus(1'b0, ADDR_I2C_TIMING, 32'h0000_0000, 4'hf, 1'b0);
      `CHK(rdat, {24'h00_0000, sh1})
    end
    $display("test timing done");
  endtask

  // Every level code with reserved bits written high
  task automatic t_swing();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      sh2 = {c, 3'b000, c[0]};
      bus(1'b1, ADDR_SWING_WAKE, {24'hff_ffff, c, 3'b111, c[0]},
          4'hf, 1'b0);
      chk_out(sh1, sh2);
      bus(1'b0, ADDR_SWING_WAKE, 32'h0000_0000, 4'hf, 1'b0);
      `CHK(rdat, {24'h00_0000, sh2})
    end
    $display("test swing done");
  endtask

  // Masked write and an unmapped address leave the settings alone
  task automatic t_refuse();
    bus(1'b1, ADDR_SWING_WAKE, 32'h0000_00a0, 4'he, 1'b0);
    bus(1'b1, 12'h048, 32'h0000_0000, 4'hf, 1'b1);
    bus(1'b0, 12'h048, 32'h0000_0000, 4'hf, 1'b1);
    `CHK(rdat, 32'h0000_0000)
    chk_out(sh1, sh2);
    bus(1'b0, ADDR_SWING_WAKE, 32'h0000_0000, 4'hf, 1'b0);
    `CHK(rdat, {24'h00_0000, sh2})
    $display("test refuse done");
  endtask

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    err_total = 0;
    n_tests   = 0;
    sh1       = 8'hb6;
    sh2       = 8'ha0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_timing();
    t_swing();
    t_refuse();
    final_report();
  end
endmodule // test_link_i2c_and_output_config_regs
`default_nettype wire
